// ==== test/sse_seq_model.sv ====
// Sequencer model: an Avalon-MM master that loads and starts the unit.
// Assumes the bench calls its tasks; gap adds idle cycles to the one before each request.
`timescale 1ns/1ps
module sse_seq_model (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata
);
  int gap = 0;
  // Idle bus from time zero
  initial begin
    address = 6'h0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0;
  end
  // Hold the request until waitrequest is low, then release it
  task automatic acc(input logic rnw, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    repeat (gap + 1) @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rnw;
    write <= !rnw;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    acc(1'b1, a, 32'h0, q);
  endtask
endmodule

// ==== test/sse_subtract_swap_exec_checker.sv ====
// Checker for the subtract and swap execution unit.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module sse_subtract_swap_exec_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic busy,
  input wire logic done
);
  logic [15:0] opc;
  logic [31:0] dst, extHi, extLo, qv;
  logic wAcc, rdRes, startAcc, ctlWr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////
  // Accepted bus cycles and the quick constant
  assign wAcc = ce && write && !waitrequest && !busy && byteenable == 4'hF;
  assign rdRes = ce && read && !waitrequest && done && !busy &&
                 address == sse_pkg::OFS_RESULT;
  assign startAcc = wAcc && address == sse_pkg::OFS_CTRL && writedata[0];
  assign ctlWr = ce && write && !waitrequest &&
                 (address == sse_pkg::OFS_STATUS || address == sse_pkg::OFS_CTRL);
  assign qv = (opc[11:9] == 3'h0) ? sse_pkg::QUICK_EIGHT : {29'h0, opc[11:9]};
  // Shadow copies of the operand registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opc <= 16'h0;
      dst <= 32'h0;
      extHi <= 32'h0;
      extLo <= 32'h0;
    end else if (wAcc) begin
      if (address == sse_pkg::OFS_OPCODE) opc <= writedata[15:0];
      if (address == sse_pkg::OFS_DEST) dst <= writedata;
      if (address == sse_pkg::OFS_EXT_HI) extHi <= writedata;
      if (address == sse_pkg::OFS_EXT_LO) extLo <= writedata;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Bus handshake and sequencing
  AST_IDLE_READY: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high with no request");
  AST_ONE_WAIT: assert property ($rose(read || write) && ce |->
    waitrequest ##1 !waitrequest)
    else $error("request not answered after one wait state");
  AST_START_SEQ: assert property (startAcc |=>
    busy ##1 busy ##1 (!busy && done))
    else $error("operation did not finish in three edges");
  AST_DONE_STICKY: assert property (done && !ctlWr |=> done)
    else $error("done dropped without a control write");
  // Results read back after completion
  AST_SWAP_HALVES: assert property (rdRes && opc[15:3] == sse_pkg::OPC_SWAP_TOP
    |-> readdata == {dst[15:0], dst[31:16]})
    else $error("exchange result wrong");
  AST_QUICK_ADDR: assert property (rdRes && opc[15:12] == 4'h5 && opc[8] &&
    opc[5:3] == 3'h1 && opc[7:6] != 2'h0 && opc[7:6] != 2'h3
    |-> readdata == dst - qv)
    else $error("quick address result not full width");
  AST_RSVD_SIZE: assert property (rdRes && opc[15:8] == 8'h04 &&
    opc[7:6] == 2'h3 |-> readdata == dst)
    else $error("reserved size changed the destination");
  AST_IMM_LONG: assert property (rdRes && opc[15:6] == 10'h012 &&
    opc[5:3] == 3'h0 |-> readdata == dst - {extHi[15:0], extLo[15:0]})
    else $error("long immediate result wrong");
  AST_IMM_BYTE: assert property (rdRes && opc[15:6] == 10'h010 &&
    opc[5:3] == 3'h0 |-> readdata == {dst[31:8], dst[7:0] - extHi[7:0]})
    else $error("byte immediate result wrong");
  // Main scenarios reached
  COV_START: cover property (startAcc);
  COV_SWAP: cover property (rdRes && opc[15:3] == sse_pkg::OPC_SWAP_TOP);
  COV_QUICK_ADDR: cover property (rdRes && opc[15:12] == 4'h5 && opc[5:3] == 3'h1);
endmodule

bind sse_subtract_swap_exec sse_subtract_swap_exec_checker u_chk (
  .clk(clk), .resetn(resetn), .ce(ce), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .busy(busy), .done(done));

// ==== test/sse_subtract_swap_exec_tb.sv ====
// Self-checking bench for the subtract and swap execution unit.
// Assumes the sequencer model drives the bus and the checker is bound.
`timescale 1ns/1ps
module sse_subtract_swap_exec_tb;
  logic clk, resetn, ce, read, write, waitrequest, busy, done;
  logic [5:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, res, cc, stat, imm;
  logic [36:0] e;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [15:0] bad [6] = '{16'h044B, 16'h04C3, 16'h047C, 16'h5109,
                           16'h517A, 16'h93C1};
  logic [15:0] xop [3] = '{16'h9541, 16'h9541, 16'h9589};
  logic [4:0] xcc [3] = '{5'h14, 5'h10, 5'h14};
  logic [31:0] xd [3] = '{32'hAAAA_0005, 32'hAAAA_0005, 32'h0};
  logic [31:0] xs [3] = '{32'h4, 32'h4, 32'h0};
  logic [31:0] sd [2] = '{32'h0000_8001, 32'h0};
  logic [4:0] scc [2] = '{5'h13, 5'h03};
  logic [4:0] sexp [2] = '{5'h18, 5'h04};
  //////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  sse_subtract_swap_exec u_dut (.clk(clk), .resetn(resetn), .ce(ce),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .busy(busy), .done(done));
  sse_seq_model u_seq (.clk(clk), .waitrequest(waitrequest),
    .readdata(readdata), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata));
  //////////////////////////////////////////////////////////////////////////
  // Compare, verdict and hang guard
  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  // Reference subtract: sized, with optional extend and sticky zero
  function automatic logic [36:0] model(input logic [1:0] sz,
      input logic [31:0] d, s, input logic [4:0] cin, input logic ext);
    logic [32:0] t;
    logic [31:0] m, r;
    logic n, v, z;
    int w;
    w = 8 << sz;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1;
    t = {1'b0, d & m} - {1'b0, s & m} - {32'h0, cin[4] & ext};
    r = t[31:0] & m;
    n = r[w-1];
    v = (d[w-1] != s[w-1]) && (n != d[w-1]);
    z = (r == 32'h0) ? (ext ? cin[2] : 1'b1) : 1'b0;
    model = {t[w], n, z, v, t[w], (d & ~m) | r};
  endfunction
  // Load operands, start, wait for done, read back
  task automatic run(input logic [15:0] op, input logic [31:0] eh, el, d, s,
                     input logic [4:0] c);
    int i;
    u_seq.wr(sse_pkg::OFS_OPCODE, {16'h0, op});
    u_seq.wr(sse_pkg::OFS_EXT_HI, eh);
    u_seq.wr(sse_pkg::OFS_EXT_LO, el);
    u_seq.wr(sse_pkg::OFS_DEST, d);
    u_seq.wr(sse_pkg::OFS_SRC, s);
    u_seq.wr(sse_pkg::OFS_CCR, {27'h0, c});
    u_seq.wr(sse_pkg::OFS_CTRL, 32'h1);
    @(posedge clk);
    for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk);
    u_seq.rd(sse_pkg::OFS_RESULT, res);
    u_seq.rd(sse_pkg::OFS_CCR, cc);
    u_seq.rd(sse_pkg::OFS_STATUS, stat);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    u_seq.rd(sse_pkg::OFS_CCR, cc);
    chk("reset ccr", cc, {27'h0, sse_pkg::CCR_RESET});
    u_seq.wr(6'h3C, 32'hFFFF_FFFF);
    u_seq.rd(6'h3C, cc);
    chk("unmapped", cc, 32'h0);
    $display("test reset finished");
    for (int sz = 0; sz < 3; sz++) begin
      imm = (sz == 0) ? 32'h0000_00F1 : (sz == 1) ? 32'h0000_80F1 : 32'h80F1_0002;
      run(16'(16'h0403 | (sz << 6)), 32'h80F1, 32'h2, 32'h1234_0001, 32'h0, 5'h0);
      e = model(sz[1:0], 32'h1234_0001, imm, 5'h0, 1'b0);
      chk("imm result", res, e[31:0]);
      chk("imm flags", cc, {27'h0, e[36:32]});
      chk("imm size", {30'h0, stat[7:6]}, 32'(sz));
    end
    $display("test immediate finished");
    foreach (bad[i]) begin
      run(bad[i], 32'h1, 32'h0, 32'hCAFE_0001, 32'h1, 5'h15);
      chk("bad result", res, 32'hCAFE_0001);
      chk("bad flags", cc, 32'h15);
      chk("bad status", {31'h0, stat[2]}, 32'h1);
    end
    $display("test refused forms finished");
    for (int q = 0; q < 8; q++) begin
      run(16'(16'h5102 | (q << 9)), 32'h0, 32'h0, 32'h1111_1105, 32'h0, 5'h0);
      e = model(2'h0, 32'h1111_1105, (q == 0) ? 32'h8 : 32'(q), 5'h0, 1'b0);
      chk("quick result", res, e[31:0]);
      chk("quick flags", cc, {27'h0, e[36:32]});
      chk("quick kind", {30'h0, stat[5:4]}, 32'h1);
    end
    u_seq.gap = 2;
    for (int sz = 1; sz < 3; sz++) begin
      run(16'(16'h5309 | (sz << 6)), 32'h0, 32'h0, 32'h0001_0000, 32'h0, 5'h1F);
      chk("addr result", res, 32'h0000_FFFF);
      chk("addr flags", cc, 32'h1F);
      chk("addr dest", {31'h0, stat[9]}, 32'h1);
    end
    u_seq.gap = 0;
    $display("test quick finished");
    foreach (xop[i]) begin
      run(xop[i], 32'h0, 32'h0, xd[i], xs[i], xcc[i]);
      e = model(xop[i][7:6], xd[i], xs[i], xcc[i], 1'b1);
      chk("ext result", res, e[31:0]);
      chk("ext flags", cc, {27'h0, e[36:32]});
      chk("ext mode", {31'h0, stat[8]}, {31'h0, xop[i][3]});
    end
    $display("test extend finished");
    foreach (sd[i]) begin
      run(16'h4845, 32'h0, 32'h0, sd[i], 32'h0, scc[i]);
      chk("swap result", res, {sd[i][15:0], sd[i][31:16]});
      chk("swap flags", cc, {27'h0, sexp[i]});
    end
    $display("test exchange finished");
    close_out();
  end
endmodule

// ==== verilog/sse_pkg.sv ====
// Constants for the subtract and swap execution block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package sse_pkg;

  // Register byte offsets
  localparam logic [5:0] OFS_OPCODE = 6'h00;
  localparam logic [5:0] OFS_EXT_HI = 6'h04;
  localparam logic [5:0] OFS_EXT_LO = 6'h08;
  localparam logic [5:0] OFS_DEST = 6'h0C;
  localparam logic [5:0] OFS_SRC = 6'h10;
  localparam logic [5:0] OFS_CCR = 6'h14;
  localparam logic [5:0] OFS_CTRL = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1C;
  localparam logic [5:0] OFS_RESULT = 6'h20;

  // Condition code bit positions
  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_X = 4;
  localparam logic [4:0] CCR_RESET = 5'h00;

  // Control and status bit positions
  localparam int CTRL_START = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_KIND_LO = 4;
  localparam int ST_SIZE_LO = 6;
  localparam int ST_PREDEC = 8;
  localparam int ST_ADDR_DEST = 9;
  localparam int ST_DREG_LO = 12;
  localparam int ST_SREG_LO = 16;

  // Size field codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_RSVD = 2'h3;

  // Effective address mode codes
  localparam logic [2:0] EA_DATA_REG = 3'h0;
  localparam logic [2:0] EA_ADDR_REG = 3'h1;
  localparam logic [2:0] EA_IND_FIRST = 3'h2;
  localparam logic [2:0] EA_IND_LAST = 3'h6;
  localparam logic [2:0] EA_EXT = 3'h7;
  localparam logic [2:0] EA_ABS_SHORT = 3'h0;
  localparam logic [2:0] EA_ABS_LONG = 3'h1;

  // Opcode patterns
  localparam logic [7:0] OPC_IMM_HI = 8'h04;
  localparam logic [3:0] OPC_QUICK_TOP = 4'h5;
  localparam logic [3:0] OPC_EXT_TOP = 4'h9;
  localparam logic [12:0] OPC_SWAP_TOP = 13'h0908;
  localparam logic [1:0] EXT_FIXED = 2'h0;

  // Quick data code that stands for eight
  localparam logic [2:0] QUICK_EIGHT_CODE = 3'h0;
  localparam logic [31:0] QUICK_EIGHT = 32'h0000_0008;

  // Operation kinds reported in status
  typedef enum logic [1:0] {
    KIND_IMM = 2'h0,
    KIND_QUICK = 2'h1,
    KIND_EXT = 2'h2,
    KIND_SWAP = 2'h3
  } sse_kind_t;

  // Sequencer states, one bit changes per step except EXEC back to IDLE
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DECODE = 2'h1,
    ST_EXEC = 2'h3
  } sse_state_t;

endpackage

// ==== verilog/sse_sub_core.sv ====
// Sized subtractor with borrow, overflow, sign and zero detection.
// Assumes operands are already aligned to bit 0; upper bits are ignored.
`timescale 1ns/1ps
module sse_sub_core (
  input wire logic [31:0] minuend,
  input wire logic [31:0] subtrahend,
  input wire logic extendIn,
  input wire logic [1:0] size,
  output logic [31:0] diff,
  output logic borrow,
  output logic overflow,
  output logic negative,
  output logic zero
);

  logic [31:0] zeroMask;
  logic [4:0] msb;
  logic am;
  logic bm;
  logic dm;

  // Difference includes the extend input as an extra borrow
  assign diff = minuend - subtrahend - {31'h0000_0000, extendIn};

  // Select the sign bit and the active lanes for the size
  always_comb begin
    case (size)
      sse_pkg::SIZE_BYTE: begin
        msb = 5'h07;
        zeroMask = 32'h0000_00FF;
      end
      sse_pkg::SIZE_WORD: begin
        msb = 5'h0F;
        zeroMask = 32'h0000_FFFF;
      end
      default: begin
        msb = 5'h1F;
        zeroMask = 32'hFFFF_FFFF;
      end
    endcase
  end

  assign am = minuend[msb];
  assign bm = subtrahend[msb];
  assign dm = diff[msb];

  // Borrow out of the sign position and signed overflow
  assign borrow = (~am & bm) | (~(am ^ bm) & dm);
  assign overflow = (am ^ bm) & (am ^ dm);
  assign negative = dm;
  assign zero = ((diff & zeroMask) == 32'h0000_0000);

endmodule

// ==== verilog/sse_subtract_swap_exec.sv ====
// Execution unit for subtract immediate, subtract quick, subtract with
// extend and register-half exchange, reached over Avalon-MM.
// Assumes the sequencer loads the opcode, extension words and operands,
// starts the unit, and then performs the writeback it reports.
// Operation
// - Immediate subtract writes destination minus immediate back.
// - Immediate width always equals the selected operation size.
// - Size field 00 byte, 01 word, 10 long.
// - Immediate: byte low of word, whole word, or two words.
// - Immediate subtract destination must be data alterable only.
// - Immediate or quick to non-address sets X N Z V C normally.
// - Quick subtract removes a constant 1 to 8 from destination.
// - Quick data codes 1-7 mean 1-7, code 0 means 8.
// - Quick to address register: word or long only, flags kept.
// - Quick to address register uses all 32 bits.
// - Quick destination: all alterable modes, address direct included.
// - Extend subtract: destination minus source minus extend flag.
// - Mode bit 0 register pair, 1 memory pair with predecrement.
// - Extend subtract clears Z only on nonzero result.
// - Exchange swaps register halves and writes back.
// - Exchange: N msb, Z all zero, V C cleared, X kept.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sse_subtract_swap_exec (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic busy,
  output logic done
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic ack_reg;
  logic ack_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic [15:0] opcode_reg;
  logic [15:0] opcode_next;
  logic [15:0] extHi_reg;
  logic [15:0] extHi_next;
  logic [15:0] extLo_reg;
  logic [15:0] extLo_next;
  logic [31:0] dest_reg;
  logic [31:0] dest_next;
  logic [31:0] src_reg;
  logic [31:0] src_next;
  logic [4:0] ccr_reg;
  logic [4:0] ccr_next;
  logic [31:0] result_reg;
  logic [31:0] result_next;
  sse_pkg::sse_state_t state_reg;
  sse_pkg::sse_state_t state_next;
  sse_pkg::sse_kind_t kind_reg;
  sse_pkg::sse_kind_t kind_next;
  logic [1:0] size_reg;
  logic [1:0] size_next;
  logic illegal_reg;
  logic illegal_next;
  logic done_reg;
  logic done_next;
  logic predec_reg;
  logic predec_next;
  logic addrDest_reg;
  logic addrDest_next;

  logic [31:0] beMask;
  logic wrTake;
  logic [31:0] wrMerged;
  logic [2:0] eaMode;
  logic [2:0] eaReg;
  logic sizeOk;
  logic eaIndirect;
  logic eaAbsolute;
  logic isImm;
  logic isQuick;
  logic isExt;
  logic isSwap;
  logic [31:0] immValue;
  logic [31:0] quickValue;
  logic [31:0] subA;
  logic [31:0] subB;
  logic subtract_with_extend_op;
  logic [1:0] subSize;
  logic [31:0] diff;
  logic borrow;
  logic overflow;
  logic negative;
  logic zero;
  logic [31:0] swapped;
  logic [31:0] status;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  // Expand byte enables to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gBe
      assign beMask[gi*8 +: 8] = {8{byteenable[gi]}};
    end
  endgenerate

  // One wait state; write and read data complete on the ack cycle
  assign waitrequest = (read | write) & ~ack_reg;
  assign wrTake = write & ack_reg & ce;
  assign readdata = readdata_reg;
  assign busy = (state_reg != sse_pkg::ST_IDLE);
  assign done = done_reg;

  // Status word built from the execution state
  always_comb begin
    status = 32'h0000_0000;
    status[sse_pkg::ST_BUSY] = busy;
    status[sse_pkg::ST_DONE] = done_reg;
    status[sse_pkg::ST_ILLEGAL] = illegal_reg;
    status[sse_pkg::ST_KIND_LO +: 2] = kind_reg;
    status[sse_pkg::ST_SIZE_LO +: 2] = size_reg;
    status[sse_pkg::ST_PREDEC] = predec_reg;
    status[sse_pkg::ST_ADDR_DEST] = addrDest_reg;
    status[sse_pkg::ST_DREG_LO +: 3] = opcode_reg[11:9];
    status[sse_pkg::ST_SREG_LO +: 3] = opcode_reg[2:0];
  end

  // Handshake and read data, captured on the first request cycle
  always_comb begin
    ack_next = (read | write) & ~ack_reg;
    readdata_next = readdata_reg;
    if (read & ~ack_reg) begin
      case (address)
        sse_pkg::OFS_OPCODE: readdata_next = {16'h0000, opcode_reg};
        sse_pkg::OFS_EXT_HI: readdata_next = {16'h0000, extHi_reg};
        sse_pkg::OFS_EXT_LO: readdata_next = {16'h0000, extLo_reg};
        sse_pkg::OFS_DEST: readdata_next = dest_reg;
        sse_pkg::OFS_SRC: readdata_next = src_reg;
        sse_pkg::OFS_CCR: readdata_next = {27'h0000000, ccr_reg};
        sse_pkg::OFS_STATUS: readdata_next = status;
        sse_pkg::OFS_RESULT: readdata_next = result_reg;
        default: readdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      ack_reg <= ack_next;
      readdata_reg <= readdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand registers written by the sequencer

  assign wrMerged = writedata & beMask;

  // Operands are frozen while an operation runs
  always_comb begin
    opcode_next = opcode_reg;
    extHi_next = extHi_reg;
    extLo_next = extLo_reg;
    dest_next = dest_reg;
    src_next = src_reg;
    if (wrTake && !busy) begin
      case (address)
        sse_pkg::OFS_OPCODE:
          opcode_next = (opcode_reg & ~beMask[15:0]) | wrMerged[15:0];
        sse_pkg::OFS_EXT_HI:
          extHi_next = (extHi_reg & ~beMask[15:0]) | wrMerged[15:0];
        sse_pkg::OFS_EXT_LO:
          extLo_next = (extLo_reg & ~beMask[15:0]) | wrMerged[15:0];
        sse_pkg::OFS_DEST: dest_next = (dest_reg & ~beMask) | wrMerged;
        sse_pkg::OFS_SRC: src_next = (src_reg & ~beMask) | wrMerged;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      opcode_reg <= 16'h0000;
      extHi_reg <= 16'h0000;
      extLo_reg <= 16'h0000;
      dest_reg <= 32'h0000_0000;
      src_reg <= 32'h0000_0000;
    end else if (ce) begin
      opcode_reg <= opcode_next;
      extHi_reg <= extHi_next;
      extLo_reg <= extLo_next;
      dest_reg <= dest_next;
      src_reg <= src_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode

  assign eaMode = opcode_reg[5:3];
  assign eaReg = opcode_reg[2:0];
  assign sizeOk = (opcode_reg[7:6] != sse_pkg::SIZE_RSVD);
  assign eaIndirect = (eaMode >= sse_pkg::EA_IND_FIRST) &&
                      (eaMode <= sse_pkg::EA_IND_LAST);
  assign eaAbsolute = (eaMode == sse_pkg::EA_EXT) &&
                      ((eaReg == sse_pkg::EA_ABS_SHORT) ||
                       (eaReg == sse_pkg::EA_ABS_LONG));

  // Data alterable destinations only
  assign isImm = (opcode_reg[15:8] == sse_pkg::OPC_IMM_HI) && sizeOk &&
                  ((eaMode == sse_pkg::EA_DATA_REG) || eaIndirect ||
                   eaAbsolute);

  // All alterable destinations, address direct at word or long
  assign isQuick = (opcode_reg[15:12] == sse_pkg::OPC_QUICK_TOP) &&
                  opcode_reg[8] && sizeOk &&
                  ((eaMode == sse_pkg::EA_DATA_REG) || eaIndirect ||
                   eaAbsolute ||
                   ((eaMode == sse_pkg::EA_ADDR_REG) &&
                    (opcode_reg[7:6] != sse_pkg::SIZE_BYTE)));

  assign isExt = (opcode_reg[15:12] == sse_pkg::OPC_EXT_TOP) &&
                  opcode_reg[8] && sizeOk &&
                  (opcode_reg[5:4] == sse_pkg::EXT_FIXED);
  assign isSwap = (opcode_reg[15:3] == sse_pkg::OPC_SWAP_TOP);

  // Immediate sized to the operation
  always_comb begin
    case (opcode_reg[7:6])
      sse_pkg::SIZE_BYTE: immValue = {24'h000000, extHi_reg[7:0]};
      sse_pkg::SIZE_WORD: immValue = {16'h0000, extHi_reg};
      default: immValue = {extHi_reg, extLo_reg};
    endcase
  end

  // Quick data, code zero meaning eight
  assign quickValue = (opcode_reg[11:9] == sse_pkg::QUICK_EIGHT_CODE) ?
                      sse_pkg::QUICK_EIGHT :
                      {29'h00000000, opcode_reg[11:9]};

  ////////////////////////////////////////////////////////////////////////
  // Datapath

  // Operand select for the shared subtractor
  always_comb begin
    subA = dest_reg;
    subB = 32'h0000_0000;
    subtract_with_extend_op = 1'b0;
    subSize = size_reg;
    case (kind_reg)
      sse_pkg::KIND_IMM: subB = immValue;
      sse_pkg::KIND_QUICK: begin
        subB = quickValue;
        if (addrDest_reg) begin
          subSize = sse_pkg::SIZE_LONG;
        end
      end
      sse_pkg::KIND_EXT: begin
        subB = src_reg;
        subtract_with_extend_op = ccr_reg[sse_pkg::CCR_X];
      end
      default: subB = 32'h0000_0000;
    endcase
  end

  sse_sub_core uSub (
    .minuend(subA),
    .subtrahend(subB),
    .extendIn(subtract_with_extend_op),
    .size(subSize),
    .diff(diff),
    .borrow(borrow),
    .overflow(overflow),
    .negative(negative),
    .zero(zero)
  );

  assign swapped = {dest_reg[15:0], dest_reg[31:16]};

  ////////////////////////////////////////////////////////////////////////
  // Sequencer, result and condition codes

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    size_next = size_reg;
    illegal_next = illegal_reg;
    predec_next = predec_reg;
    addrDest_next = addrDest_reg;
    result_next = result_reg;
    ccr_next = ccr_reg;
    done_next = done_reg;
    // Software write to the condition codes, e.g. presetting Z
    if (wrTake && !busy && (address == sse_pkg::OFS_CCR) &&
        byteenable[0]) begin
      ccr_next = writedata[4:0];
    end
    // Software clears done by writing one; completion wins
    if (wrTake && (address == sse_pkg::OFS_STATUS) && byteenable[0] &&
        writedata[sse_pkg::ST_DONE]) begin
      done_next = 1'b0;
    end
    case (state_reg)
      sse_pkg::ST_IDLE: begin
        if (wrTake && (address == sse_pkg::OFS_CTRL) && byteenable[0] &&
            writedata[sse_pkg::CTRL_START]) begin
          state_next = sse_pkg::ST_DECODE;
          done_next = 1'b0;
        end
      end
      sse_pkg::ST_DECODE: begin
        size_next = opcode_reg[7:6];
        predec_next = 1'b0;
        addrDest_next = 1'b0;
        illegal_next = 1'b0;
        if (isImm) begin
          kind_next = sse_pkg::KIND_IMM;
        end else if (isQuick) begin
          kind_next = sse_pkg::KIND_QUICK;
          addrDest_next = (eaMode == sse_pkg::EA_ADDR_REG);
        end else if (isExt) begin
          kind_next = sse_pkg::KIND_EXT;
          predec_next = opcode_reg[3];
        end else if (isSwap) begin
          kind_next = sse_pkg::KIND_SWAP;
          size_next = sse_pkg::SIZE_WORD;
        end else begin
          illegal_next = 1'b1;
        end
        state_next = sse_pkg::ST_EXEC;
      end
      sse_pkg::ST_EXEC: begin
        state_next = sse_pkg::ST_IDLE;
        done_next = 1'b1;
        if (illegal_reg) begin
          result_next = dest_reg;
        end else if (kind_reg == sse_pkg::KIND_SWAP) begin
          result_next = swapped;
          ccr_next[sse_pkg::CCR_N] = swapped[31];
          ccr_next[sse_pkg::CCR_Z] = (swapped == 32'h0000_0000);
          ccr_next[sse_pkg::CCR_V] = 1'b0;
          ccr_next[sse_pkg::CCR_C] = 1'b0;
        end else begin
          // Merge the sized difference into the untouched upper bits
          case (subSize)
            sse_pkg::SIZE_BYTE: result_next = {dest_reg[31:8], diff[7:0]};
            sse_pkg::SIZE_WORD: result_next = {dest_reg[31:16], diff[15:0]};
            default: result_next = diff;
          endcase
          if (kind_reg == sse_pkg::KIND_EXT) begin
            ccr_next[sse_pkg::CCR_X] = borrow;
            ccr_next[sse_pkg::CCR_C] = borrow;
            ccr_next[sse_pkg::CCR_N] = negative;
            ccr_next[sse_pkg::CCR_V] = overflow;
            if (!zero) begin
              ccr_next[sse_pkg::CCR_Z] = 1'b0;
            end
          end else if (!addrDest_reg) begin
            ccr_next[sse_pkg::CCR_X] = borrow;
            ccr_next[sse_pkg::CCR_C] = borrow;
            ccr_next[sse_pkg::CCR_N] = negative;
            ccr_next[sse_pkg::CCR_Z] = zero;
            ccr_next[sse_pkg::CCR_V] = overflow;
          end
        end
      end
      default: state_next = sse_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= sse_pkg::ST_IDLE;
      kind_reg <= sse_pkg::KIND_IMM;
      size_reg <= sse_pkg::SIZE_BYTE;
      illegal_reg <= 1'b0;
      predec_reg <= 1'b0;
      addrDest_reg <= 1'b0;
      result_reg <= 32'h0000_0000;
      ccr_reg <= sse_pkg::CCR_RESET;
      done_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      size_reg <= size_next;
      illegal_reg <= illegal_next;
      predec_reg <= predec_next;
      addrDest_reg <= addrDest_next;
      result_reg <= result_next;
      ccr_reg <= ccr_next;
      done_reg <= done_next;
    end
  end

endmodule
